// ==== bench/sae_host_model.sv ====
// Purpose: Host controller model that reads the alarm outputs
// Assumes: Clear request is a one-cycle pulse
// Notes: Run is dropped while the reset pin is raised
`timescale 1ns/100ps
module sae_host_model (
    input wire logic clk,
    input wire logic flag,
    input wire logic [2:0] bits,
    input wire logic clear_req,
    output logic reset_pin = 1'b0,
    output logic run_pin = 1'b1,
    output logic [2:0] seen = 3'h0
);
    int hold = 0;
    always @(posedge clk)
    begin
        if (flag === 1'b0)
            seen <= bits;
        if (clear_req)
        begin
            run_pin <= 1'b0;
            reset_pin <= 1'b1;
            hold <= 4;
        end
        else if (hold > 1)
            hold <= hold - 1;
        else if (hold == 1)
        begin
            reset_pin <= 1'b0;
            run_pin <= 1'b1;
            hold <= 0;
        end
    end
endmodule

// ==== bench/tb_servo_alarm_encoder.sv ====
// Purpose: Self-checking bench of the servo alarm encoder
// Assumes: Default variant, host model on the pins
// Notes: Expected values come from a table and a queue
`timescale 1ns/100ps
module tb_servo_alarm_encoder;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic [9:0] err = 10'h000;
    logic [15:0] dev = 16'h0000, thr = 16'hffff, fsw = 16'h0000, pcd;
    logic [12:0] spd = 13'h0000, cmd = 13'h0000;
    logic [7:0] tq = 8'h00, sel = 8'h00, disp, hist;
    logic pwr = 1'b0, lok = 1'b0, lto = 1'b0;
    logic krst = 1'b0, kmode = 1'b0, creq = 1'b0;
    logic [3:0] idx = 4'h0;
    logic rpin, run, flag, b1, b2, b3, drv, pca, pcs;
    logic [2:0] seen;
    int n_mismatch = 0, check_count = 0, seed = 17607;
    int hq[$];
    int ec[12] = '{8'h02, 8'h04, 8'h10, 8'h40, 8'hc1, 8'hc2, 8'hc3,
                   8'hc4, 8'hf3, 8'h70, 8'h31, 8'h51};
    int ep[12] = '{3'h0, 3'h0, 3'h1, 3'h4, 3'h5, 3'h5, 3'h5, 3'h5,
                   3'h2, 3'h7, 3'h3, 3'h5};
    sae_alarm_encoder #(.SPECIAL_SPEC(16'h5a5a)) u_dut (
        .CLK(CLK), .RST(RST), .ERR_CHECKSUM(err[0]),
        .ERR_PARAM_SETTING(err[1]), .ERR_OVERCURRENT(err[2]),
        .DEV_COUNT(dev), .OVERFLOW_THRESHOLD_PARAM(thr),
        .ERR_OVERVOLTAGE(err[3]), .MOTOR_SPEED(spd), .SPEED_CMD(cmd),
        .OVERLOAD_TRIP(err[9]), .TORQUE_PCT(tq), .ERR_RUNAWAY(err[4]),
        .ERR_PHASE(err[5]), .ERR_ENC_QUAD(err[6]),
        .ERR_ENC_SERIAL(err[7]), .ERR_POWER_RESTART(err[8]),
        .PWR_CYCLE(pwr), .LINK_OK(lok), .LINK_TIMEOUT(lto),
        .ALARM_RESET_PIN(rpin), .RUN_PIN(run), .KEY_RESET(krst),
        .KEY_MODE_SET(kmode), .FUNCTION_SELECT_WORD(fsw),
        .SYSTEM_CHECK_SELECTOR(sel), .HIST_RD_IDX(idx),
        .FAULT_FLAG_OUT(flag), .FAULT_CODE_BIT1(b1),
        .FAULT_CODE_BIT2(b2), .FAULT_CODE_BIT3(b3), .DRIVE_ENABLE(drv),
        .DISPLAY_CODE(disp), .PCHECK_ACTIVE(pca), .PCHECK_SPECIAL(pcs),
        .PCHECK_DATA(pcd), .HIST_RD_CODE(hist)
    );
    sae_host_model u_host (.clk(CLK), .flag(flag), .bits({b3, b2, b1}),
        .clear_req(creq), .reset_pin(rpin), .run_pin(run), .seen(seen));
    always #25 CLK = ~CLK;
    task automatic chk(input logic ok);
        check_count++;
        if (ok !== 1'b1)
        begin
            n_mismatch++;
            $display("FAIL %0t mismatch at check %0d", $time, check_count);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // A lowest-priority restart error rides along with every fault
    task automatic fire(input int i);
        @(posedge CLK);
        err <= (i < 10 ? 10'h001 << i : 10'h000) | 10'h100;
        dev <= i == 10 ? thr + 16'h0001 : 16'h0000;
        spd <= i == 11 ? 13'h1356 : 13'h0000;
        fsw <= 16'($random(seed));
        @(posedge CLK);
        {err, dev, spd} <= 39'h0;
        thr <= {1'b0, 15'($random(seed))};
        #1;
    endtask
    task automatic clear(input int how);
        @(posedge CLK);
        {krst, creq, pwr} <= 3'h4 >> how;
        @(posedge CLK);
        {krst, creq, pwr} <= 3'h0;
        repeat (12) if (flag !== 1'b1 && how == 1) @(posedge CLK) #1;
        #1;
    endtask
    task automatic press();
        @(posedge CLK) kmode <= 1'b1;
        @(posedge CLK) kmode <= 1'b0;
        #1;
    endtask
    initial
    begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end
    initial
    begin
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        tq <= 8'h79 + 8'($random(seed) & 63);
        cmd <= 13'($random(seed));
        @(posedge CLK) #1;
        chk(flag === 1'b1 && disp === 8'h00 && hist === 8'h00);
        for (int i = 0; i < 12; i++)
        begin
            fire(i);
            chk(flag === 1'b0 && drv === 1'b0);
            chk(disp === 8'(ec[i]));
            chk({b3, b2, b1} === 3'(ep[i]));
            hq.push_front(ec[i]);
            @(posedge CLK) #1;
            chk(hist === 8'(hq[0]));
            chk(seen === 3'(ep[i]));
            clear(i % 3);
            chk(flag === 1'(i != 2));
            if (i % 3 == 2 && i != 2)
                hq.push_front(8'h99);
            if (i == 2)
                clear(0);
            chk(drv === (i % 3 == 1 ? fsw[0] : 1'b1));
            while (hq.size() > 10)
                void'(hq.pop_back());
            @(posedge CLK) #1;
            chk(hist === 8'(hq[0]));
        end
        for (int k = 0; k < 2; k++)
        begin
            @(posedge CLK) lto <= 1'b1;
            @(posedge CLK) lto <= 1'b0;
            #1;
            chk(flag === 1'b0 && disp === 8'(8'he0 + k));
            chk({b3, b2, b1} === 3'h0);
            clear(0);
            @(posedge CLK) lok <= 1'b1;
            @(posedge CLK) lok <= 1'b0;
        end
        @(posedge CLK) sel <= 8'h04;
        #1;
        chk(hist === 8'(hq[0]));
        for (int k = 0; k < 6; k++)
        begin
            press();
            chk(pca === 1'(k < 5) && pcs === 1'(k == 4));
            chk(pcd === (k < 4 ? 16'(k + 1) :
                k == 4 ? 16'h5a5a : 16'h0));
        end
        @(posedge CLK) idx <= 4'h9;
        @(posedge CLK) #1;
        chk(hist === 8'(hq[9]));
        @(posedge CLK) sel <= 8'h02;
        press();
        @(posedge CLK) #1;
        chk(hist === 8'h00);
        tally_and_finish();
    end
endmodule

// ==== core/sae_alarm_encoder.sv ====
// Purpose: Alarm detection, latching, code outputs and parameter check
// Assumes: Error inputs come from logic on CLK; RESET and RUN are pins
// Notes: Power cycle is a pulse from the retained supervisor logic
// Behaviour
// [R01] Any error drops fault flag, drives code bits, stops drive, shows code
// [R02] Parameter checksum mismatch gives a.02 with all code bits off
// [R03] Overcurrent or overheat gives a.10 with only bit 1 on
// [R04] Deviation count above threshold gives a.31, bits 1 and 2 on
// [R05] DC bus overvoltage gives a.40 with only bit 3 on
// [R06] Speed at 4950 r/min gives a.51, bits 1 and 3 on
// [R07] On other variants a 4700 r/min command gives a.52, bits 1, 3
// [R08] Supporting variants: torque over 120% along curve gives a.70, all on
// [R09] Other variants: torque over 135% along curve gives a.71, all on
// [R10] Other variants: torque 120% to 135% along curve gives a.72, all on
// [R11] Runaway a.c1 and phase error a.c2 set bits 1 and 3
// [R12] Quadrature channel open or short gives a.c3, bits 1 and 3
// [R13] Serial encoder channel open or short gives a.c4, bits 1 and 3
// [R14] Restart within retention gives a.f3 with only bit 2 on
// [R15] a.99 logged at power-up after alarm reset, never an active alarm
// [R16] Link faults cpf00 and cpf01 reported, never kept in history
// [R17] Fault flag high in normal running, low while alarm is active
// [R18] Reset pin, power cycle or reset key clears the alarm
// [R19] Power cycle does not clear an overcurrent alarm
// [R20] Drive resumes at once on clear if run or always-on is set
// [R21] Selector 04 enters check mode showing the drive's supported ratings
// [R22] Mode key steps motor items, then special specs, then back
// [R23] Ten most recent alarms kept, higher entry is older; an alarm detected with LINK_TIMEOUT in the same cycle is not logged
// [R24] Only the first detected code is latched until cleared
`timescale 1ns/100ps
module sae_alarm_encoder #(
    parameter logic VARIANT_HL = 1'b0,
    parameter logic [3:0][15:0] MOTOR_PARAMS = 64'h0004_0003_0002_0001,
    parameter logic [15:0] SPECIAL_SPEC = 16'h0000
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic ERR_CHECKSUM,
    input wire logic ERR_PARAM_SETTING,
    input wire logic ERR_OVERCURRENT,
    input wire logic [15:0] DEV_COUNT,
    input wire logic [15:0] OVERFLOW_THRESHOLD_PARAM,
    input wire logic ERR_OVERVOLTAGE,
    input wire logic [12:0] MOTOR_SPEED,
    input wire logic [12:0] SPEED_CMD,
    input wire logic OVERLOAD_TRIP,
    input wire logic [7:0] TORQUE_PCT,
    input wire logic ERR_RUNAWAY,
    input wire logic ERR_PHASE,
    input wire logic ERR_ENC_QUAD,
    input wire logic ERR_ENC_SERIAL,
    input wire logic ERR_POWER_RESTART,
    input wire logic PWR_CYCLE,
    input wire logic LINK_OK,
    input wire logic LINK_TIMEOUT,
    input wire logic ALARM_RESET_PIN,
    input wire logic RUN_PIN,
    input wire logic KEY_RESET,
    input wire logic KEY_MODE_SET,
    input wire logic [15:0] FUNCTION_SELECT_WORD,
    input wire logic [7:0] SYSTEM_CHECK_SELECTOR,
    input wire logic [3:0] HIST_RD_IDX,
    output logic FAULT_FLAG_OUT,
    output logic FAULT_CODE_BIT1,
    output logic FAULT_CODE_BIT2,
    output logic FAULT_CODE_BIT3,
    output logic DRIVE_ENABLE,
    output logic [7:0] DISPLAY_CODE,
    output logic PCHECK_ACTIVE,
    output logic PCHECK_SPECIAL,
    output logic [15:0] PCHECK_DATA,
    output logic [7:0] HIST_RD_CODE
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic rst_pin_m;
    logic rst_pin_s;
    logic rst_pin_d;
    logic run_m;
    logic run_s;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            rst_pin_m <= 1'b0;
            rst_pin_s <= 1'b0;
            rst_pin_d <= 1'b0;
            run_m <= 1'b0;
            run_s <= 1'b0;
        end
        else
        begin
            rst_pin_m <= ALARM_RESET_PIN;
            rst_pin_s <= rst_pin_m;
            rst_pin_d <= rst_pin_s;
            run_m <= RUN_PIN;
            run_s <= run_m;
        end
    end

    wire reset_edge = rst_pin_s & ~rst_pin_d;

    // ----------------------------------------------------------------
    // Error detection
    // ----------------------------------------------------------------
    logic link_seen;

    // [R02] checksum error
    wire det_a02 = ERR_CHECKSUM;
    wire det_a04 = ERR_PARAM_SETTING & ~VARIANT_HL;
    // [R03] overcurrent or heat
    wire det_a10 = ERR_OVERCURRENT;
    // [R04] deviation overflow
    wire det_a31 = DEV_COUNT > OVERFLOW_THRESHOLD_PARAM;
    // [R05] bus overvoltage
    wire det_a40 = ERR_OVERVOLTAGE;
    // [R06] overspeed limit
    wire det_a51 = MOTOR_SPEED >= sae_pkg::OVERSPEED_RPM;
    // [R07] excessive speed command
    wire det_a52 = VARIANT_HL & (SPEED_CMD >= sae_pkg::SPEED_CMD_LIMIT_RPM);
    wire over_low = TORQUE_PCT > sae_pkg::TORQUE_LOW_PCT;
    wire over_high = TORQUE_PCT > sae_pkg::TORQUE_HIGH_PCT;
    wire in_band = (TORQUE_PCT >= sae_pkg::TORQUE_LOW_PCT) & ~over_high;
    // [R08] overload above low level
    wire det_a70 = OVERLOAD_TRIP & ~VARIANT_HL & over_low;
    // [R09] overload above high level
    wire det_a71 = OVERLOAD_TRIP & VARIANT_HL & over_high;
    // [R10] overload in band
    wire det_a72 = OVERLOAD_TRIP & VARIANT_HL & in_band;
    // [R11] runaway and phase
    wire det_ac1 = ERR_RUNAWAY;
    wire det_ac2 = ERR_PHASE;
    // [R12] quadrature wire fault
    wire det_ac3 = ERR_ENC_QUAD;
    // [R13] serial wire fault
    wire det_ac4 = ERR_ENC_SERIAL;
    // [R14] momentary power failure
    wire det_af3 = ERR_POWER_RESTART;
    // [R16] link fault classes
    wire det_cpf00 = LINK_TIMEOUT & ~link_seen;
    wire det_cpf01 = LINK_TIMEOUT & link_seen;

    // [R24] fixed pick among same-cycle errors
    wire [7:0] det_code =
        det_a02 ? sae_pkg::CODE_A02 :
        det_a04 ? sae_pkg::CODE_A04 :
        det_a10 ? sae_pkg::CODE_A10 :
        det_a31 ? sae_pkg::CODE_A31 :
        det_a40 ? sae_pkg::CODE_A40 :
        det_a51 ? sae_pkg::CODE_A51 :
        det_a52 ? sae_pkg::CODE_A52 :
        det_a70 ? sae_pkg::CODE_A70 :
        det_a71 ? sae_pkg::CODE_A71 :
        det_a72 ? sae_pkg::CODE_A72 :
        det_ac1 ? sae_pkg::CODE_AC1 :
        det_ac2 ? sae_pkg::CODE_AC2 :
        det_ac3 ? sae_pkg::CODE_AC3 :
        det_ac4 ? sae_pkg::CODE_AC4 :
        det_af3 ? sae_pkg::CODE_AF3 :
        det_cpf00 ? sae_pkg::CODE_CPF00 :
        det_cpf01 ? sae_pkg::CODE_CPF01 : sae_pkg::CODE_NONE;

    wire det_any = det_code != sae_pkg::CODE_NONE;
    wire det_link = det_cpf00 | det_cpf01;

    // ----------------------------------------------------------------
    // Alarm latch and clearing
    // ----------------------------------------------------------------
    logic [7:0] alarm_code;

    wire alarm_active = alarm_code != sae_pkg::CODE_NONE;
    wire is_overcurrent = alarm_code == sae_pkg::CODE_A10;
    // [R19] power cycle spares overcurrent
    wire pwr_clear = PWR_CYCLE & alarm_active & ~is_overcurrent;
    // [R18] three ways to clear
    wire do_clear = reset_edge | KEY_RESET | pwr_clear;
    // [R24] new code only when idle or cleared; set wins over clear
    wire take_new = det_any & (~alarm_active | do_clear);
    wire [7:0] next_alarm_code = take_new ? det_code :
        do_clear ? sae_pkg::CODE_NONE : alarm_code;
    wire next_active = next_alarm_code != sae_pkg::CODE_NONE;
    wire always_on = FUNCTION_SELECT_WORD[sae_pkg::ALWAYS_ON_BIT];
    wire drive_req = run_s | always_on;
    wire [2:0] next_pat = sae_pkg::sae_pattern(next_alarm_code);

    always_ff @(posedge CLK)
    begin
        if (RST)
            link_seen <= 1'b0;
        else if (LINK_OK)
            link_seen <= 1'b1;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            alarm_code <= sae_pkg::CODE_NONE;
        else
            alarm_code <= next_alarm_code;
    end

    // [R01] outputs follow the latched code
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            FAULT_FLAG_OUT <= sae_pkg::FAULT_FLAG_RST;
            {FAULT_CODE_BIT3, FAULT_CODE_BIT2, FAULT_CODE_BIT1} <=
                sae_pkg::PAT_OFF;
            DRIVE_ENABLE <= 1'b0;
            DISPLAY_CODE <= sae_pkg::CODE_NONE;
        end
        else
        begin
            // [R17] conducting while normal
            FAULT_FLAG_OUT <= ~next_active;
            {FAULT_CODE_BIT3, FAULT_CODE_BIT2, FAULT_CODE_BIT1} <= next_pat;
            // [R20] immediate resume on clear
            DRIVE_ENABLE <= ~next_active & drive_req;
            DISPLAY_CODE <= next_alarm_code;
        end
    end

    // ----------------------------------------------------------------
    // Alarm history
    // ----------------------------------------------------------------
    sae_hist_if hist_bus();

    // [R16] link faults stay out of history
    wire push_alarm = take_new & ~det_link;
    // [R15] reset-at-power-up entry only
    wire push_a99 = pwr_clear & ~take_new;
    wire hist_clear_req;

    assign hist_bus.push = push_alarm | push_a99;
    assign hist_bus.push_code = push_alarm ? det_code : sae_pkg::CODE_A99;
    assign hist_bus.clear = hist_clear_req;
    assign hist_bus.rd_idx = HIST_RD_IDX;

    // [R23] ten entry store
    sae_alarm_history #(
        .DEPTH(sae_pkg::HIST_DEPTH)
    ) u_history (
        .clk(CLK),
        .rst(RST),
        .hist(hist_bus.store)
    );

    always_ff @(posedge CLK)
    begin
        if (RST)
            HIST_RD_CODE <= sae_pkg::CODE_NONE;
        else
            HIST_RD_CODE <= hist_bus.rd_code;
    end

    // ----------------------------------------------------------------
    // Motor parameter check mode
    // ----------------------------------------------------------------
    sae_pkg::sae_pc_state_t pc_state;
    sae_pkg::sae_pc_state_t next_pc_state;
    logic [1:0] pc_idx;

    wire sel_check = SYSTEM_CHECK_SELECTOR == sae_pkg::SEL_PARAM_CHECK;
    wire sel_clear = SYSTEM_CHECK_SELECTOR == sae_pkg::SEL_HIST_CLEAR;
    wire in_idle = pc_state == sae_pkg::PC_IDLE;
    wire in_motor = pc_state == sae_pkg::PC_MOTOR;
    wire last_item = pc_idx == sae_pkg::PCHECK_LAST;
    assign hist_clear_req = in_idle & sel_clear & KEY_MODE_SET;

    // [R22] mode key stepping
    always_comb
    begin
        next_pc_state = pc_state;
        case (pc_state)
            sae_pkg::PC_IDLE:
                if (KEY_MODE_SET && sel_check)
                    next_pc_state = sae_pkg::PC_MOTOR;
            sae_pkg::PC_MOTOR:
                if (KEY_MODE_SET && last_item)
                    next_pc_state = sae_pkg::PC_SPECIAL;
            sae_pkg::PC_SPECIAL:
                if (KEY_MODE_SET)
                    next_pc_state = sae_pkg::PC_IDLE;
            default:
                next_pc_state = sae_pkg::PC_IDLE;
        endcase
    end

    wire next_in_motor = next_pc_state == sae_pkg::PC_MOTOR;
    wire [1:0] next_pc_idx = (in_motor && KEY_MODE_SET && !last_item) ?
        pc_idx + 2'h1 : (next_in_motor ? pc_idx : 2'h0);
    // [R21] ratings held by the drive itself
    wire [15:0] next_pc_data = next_in_motor ? MOTOR_PARAMS[next_pc_idx] :
        (next_pc_state == sae_pkg::PC_SPECIAL) ? SPECIAL_SPEC : 16'h0000;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            pc_state <= sae_pkg::PC_IDLE;
            pc_idx <= 2'h0;
            PCHECK_ACTIVE <= 1'b0;
            PCHECK_SPECIAL <= 1'b0;
            PCHECK_DATA <= 16'h0000;
        end
        else
        begin
            pc_state <= next_pc_state;
            pc_idx <= next_pc_idx;
            PCHECK_ACTIVE <= next_pc_state != sae_pkg::PC_IDLE;
            PCHECK_SPECIAL <= next_pc_state == sae_pkg::PC_SPECIAL;
            PCHECK_DATA <= next_pc_data;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_raise;
        @(posedge CLK) disable iff (RST)
        (!alarm_active && det_any) |=> !FAULT_FLAG_OUT && !DRIVE_ENABLE
            && DISPLAY_CODE == $past(det_code);
    endproperty
    a_raise: assert property (p_raise) // [R01]
        else $error("Detected error not raised on outputs");

    property p_a02;
        @(posedge CLK) disable iff (RST)
        (!alarm_active && ERR_CHECKSUM) |=> DISPLAY_CODE == 8'h02
            && !FAULT_CODE_BIT1 && !FAULT_CODE_BIT2 && !FAULT_CODE_BIT3;
    endproperty
    a_a02: assert property (p_a02) // [R02]
        else $error("Checksum alarm code wrong");

    property p_a10;
        @(posedge CLK) disable iff (RST)
        (!alarm_active && det_code == 8'h10) |=> FAULT_CODE_BIT1
            && !FAULT_CODE_BIT2 && !FAULT_CODE_BIT3;
    endproperty
    a_a10: assert property (p_a10) // [R03]
        else $error("Overcurrent code bits wrong");

    property p_a51;
        @(posedge CLK) disable iff (RST)
        (!alarm_active && det_code == 8'h51) |=> FAULT_CODE_BIT1
            && !FAULT_CODE_BIT2 && FAULT_CODE_BIT3;
    endproperty
    a_a51: assert property (p_a51) // [R06]
        else $error("Overspeed code bits wrong");

    property p_hold_first;
        @(posedge CLK) disable iff (RST)
        (alarm_active && !do_clear) |=> $stable(alarm_code) [*1];
    endproperty
    a_hold_first: assert property (p_hold_first) // [R24]
        else $error("Latched code changed without clear");

    property p_oc_kept;
        @(posedge CLK) disable iff (RST)
        (is_overcurrent && PWR_CYCLE && !KEY_RESET && !reset_edge)
            |=> alarm_code == 8'h10 && !FAULT_FLAG_OUT;
    endproperty
    a_oc_kept: assert property (p_oc_kept) // [R19]
        else $error("Power cycle cleared overcurrent");

    property p_key_clear;
        @(posedge CLK) disable iff (RST)
        (KEY_RESET && !det_any) |=> FAULT_FLAG_OUT && !alarm_active;
    endproperty
    a_key_clear: assert property (p_key_clear) // [R18]
        else $error("Reset key did not clear alarm");

    property p_resume;
        @(posedge CLK) disable iff (RST)
        (alarm_active && do_clear && !det_any && drive_req)
            |=> DRIVE_ENABLE;
    endproperty
    a_resume: assert property (p_resume) // [R20]
        else $error("Drive did not resume on clear");

    property p_no_link_hist;
        @(posedge CLK) disable iff (RST)
        (take_new && det_link) |-> !hist_bus.push;
    endproperty
    a_no_link_hist: assert property (p_no_link_hist) // [R16]
        else $error("Link fault entered history");

    property p_a99_passive;
        @(posedge CLK) disable iff (RST)
        push_a99 |=> FAULT_FLAG_OUT && alarm_code != 8'h99;
    endproperty
    a_a99_passive: assert property (p_a99_passive) // [R15]
        else $error("History-only entry acted as alarm");

    property p_check_enter;
        @(posedge CLK) disable iff (RST)
        (in_idle && sel_check && KEY_MODE_SET) |=> PCHECK_ACTIVE
            && !PCHECK_SPECIAL && PCHECK_DATA == MOTOR_PARAMS[0];
    endproperty
    a_check_enter: assert property (p_check_enter) // [R21]
        else $error("Check mode not entered");

    property p_check_special;
        @(posedge CLK) disable iff (RST)
        (in_motor && last_item && KEY_MODE_SET) |=> PCHECK_SPECIAL
            && PCHECK_ACTIVE && PCHECK_DATA == SPECIAL_SPEC;
    endproperty
    a_check_special: assert property (p_check_special) // [R22]
        else $error("Special specs not shown after last item");

endmodule

// ==== core/sae_alarm_history.sv ====
// Purpose: Shift store of the most recent alarm codes
// Assumes: Entry 0 is the newest code
// Notes: Clear empties every entry in one cycle; a same-cycle push survives
`timescale 1ns/100ps
module sae_alarm_history #(
    parameter int DEPTH = sae_pkg::HIST_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    sae_hist_if.store hist
);

    logic [7:0] entry [DEPTH];

    // ----------------------------------------------------------------
    // Shift chain
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < DEPTH; i++)
        begin : g_entry
            localparam int PREV = (i == 0) ? 0 : i - 1;
            // New code wins over a clear in the same cycle
            wire [7:0] shift_in = (i == 0) ? hist.push_code :
                hist.clear ? sae_pkg::CODE_NONE : entry[PREV];
            always_ff @(posedge clk)
            begin
                if (rst)
                    entry[i] <= sae_pkg::CODE_NONE;
                else if (hist.push)
                    entry[i] <= shift_in;
                else if (hist.clear)
                    entry[i] <= sae_pkg::CODE_NONE;
            end
        end
    endgenerate

    wire in_range = int'(hist.rd_idx) < DEPTH;
    assign hist.rd_code = in_range ? entry[hist.rd_idx] : sae_pkg::CODE_NONE;

    // [R23] newest first
    property p_hist_shift;
        @(posedge clk) disable iff (rst)
        (hist.push && !hist.clear) |=> (entry[0] == $past(hist.push_code))
            && (entry[1] == $past(entry[0]));
    endproperty
    a_hist_shift: assert property (p_hist_shift) // [R23]
        else $error("History did not shift in the new code");

endmodule

// ==== core/sae_hist_if.sv ====
// Purpose: Carrier between alarm encoder and its history store
// Assumes: One push per cycle at most
// Notes: Read index beyond the depth returns no code
`timescale 1ns/100ps
interface sae_hist_if;
    logic push;
    logic clear;
    logic [7:0] push_code;
    logic [3:0] rd_idx;
    logic [7:0] rd_code;

    modport writer(output push, output clear, output push_code,
                   output rd_idx, input rd_code);
    modport store(input push, input clear, input push_code,
                  input rd_idx, output rd_code);
endinterface

// ==== core/sae_pkg.sv ====
// Purpose: Shared constants, codes and types of the servo alarm encoder
// Assumes: Display codes are held as one byte each
// Notes: Link fault codes use their own byte values, e0 and e1, unused by any alarm code
package sae_pkg;

    // ----------------------------------------------------------------
    // Display codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_A02 = 8'h02;
    localparam logic [7:0] CODE_A04 = 8'h04;
    localparam logic [7:0] CODE_A10 = 8'h10;
    localparam logic [7:0] CODE_A31 = 8'h31;
    localparam logic [7:0] CODE_A40 = 8'h40;
    localparam logic [7:0] CODE_A51 = 8'h51;
    localparam logic [7:0] CODE_A52 = 8'h52;
    localparam logic [7:0] CODE_A70 = 8'h70;
    localparam logic [7:0] CODE_A71 = 8'h71;
    localparam logic [7:0] CODE_A72 = 8'h72;
    localparam logic [7:0] CODE_AC1 = 8'hc1;
    localparam logic [7:0] CODE_AC2 = 8'hc2;
    localparam logic [7:0] CODE_AC3 = 8'hc3;
    localparam logic [7:0] CODE_AC4 = 8'hc4;
    localparam logic [7:0] CODE_AF3 = 8'hf3;
    localparam logic [7:0] CODE_A99 = 8'h99;
    localparam logic [7:0] CODE_CPF00 = 8'he0;
    localparam logic [7:0] CODE_CPF01 = 8'he1;

    // ----------------------------------------------------------------
    // Code bit patterns, ordered {bit3, bit2, bit1}
    // ----------------------------------------------------------------
    localparam logic [2:0] PAT_OFF = 3'h0;
    localparam logic [2:0] PAT_B1 = 3'h1;
    localparam logic [2:0] PAT_B2 = 3'h2;
    localparam logic [2:0] PAT_B12 = 3'h3;
    localparam logic [2:0] PAT_B3 = 3'h4;
    localparam logic [2:0] PAT_B13 = 3'h5;
    localparam logic [2:0] PAT_ALL = 3'h7;

    // ----------------------------------------------------------------
    // Limits, selectors, fields and reset values
    // ----------------------------------------------------------------
    localparam logic [12:0] OVERSPEED_RPM = 13'h1356;
    localparam logic [12:0] SPEED_CMD_LIMIT_RPM = 13'h125c;
    localparam logic [7:0] TORQUE_LOW_PCT = 8'h78;
    localparam logic [7:0] TORQUE_HIGH_PCT = 8'h87;
    localparam logic [7:0] SEL_HIST_CLEAR = 8'h02;
    localparam logic [7:0] SEL_PARAM_CHECK = 8'h04;
    localparam int ALWAYS_ON_BIT = 0;
    localparam int HIST_DEPTH = 10;
    localparam logic [1:0] PCHECK_LAST = 2'h3;
    localparam logic FAULT_FLAG_RST = 1'b1;

    typedef enum logic [2:0] {
        PC_IDLE = 3'b001,
        PC_MOTOR = 3'b010,
        PC_SPECIAL = 3'b100
    } sae_pc_state_t;

    function automatic logic [2:0] sae_pattern(input logic [7:0] code);
        case (code)
            CODE_A10: sae_pattern = PAT_B1;
            CODE_A31: sae_pattern = PAT_B12;
            CODE_A40: sae_pattern = PAT_B3;
            CODE_A51, CODE_A52, CODE_AC1, CODE_AC2, CODE_AC3, CODE_AC4:
                sae_pattern = PAT_B13;
            CODE_A70, CODE_A71, CODE_A72: sae_pattern = PAT_ALL;
            CODE_AF3: sae_pattern = PAT_B2;
            default: sae_pattern = PAT_OFF;
        endcase
    endfunction

endpackage
